//--- hw/vbe_pkg.sv
package vbe_pkg;
    // register byte addresses (printed offset 0xF7 is not a multiple of four)
    localparam logic [7:0]  ERR_IDX        = 8'hF7;
    localparam logic [11:0] ERR_ADDR       = 12'h3DC;
    localparam logic [11:0] CTRL_ADDR      = 12'h000;
    localparam logic [11:0] RXD_ADDR       = 12'h004;
    localparam logic [11:0] TXD_ADDR       = 12'h008;
    // error register field positions
    localparam int          BIT_TTO        = 7;
    localparam int          BIT_TX_UNDERFLOW_FLAG       = 6;
    localparam int          BIT_RX_OVERRUN_FLAG       = 5;
    localparam int          BIT_TRA        = 4;
    localparam int          BIT_RX_BREAK_FLAG       = 3;
    localparam int          BIT_RX_CHECKSUM_ERROR_FLAG       = 2;
    localparam int          BIT_IFD        = 1;
    localparam int          BIT_IBD        = 0;
    // control register field positions
    localparam int          BIT_EN         = 0;
    localparam int          BIT_FRZ        = 1;
    localparam int          BIT_QUAD       = 2;
    localparam int          BIT_NFL        = 3;
    localparam int          BIT_SLEEP      = 4;
    localparam int          BIT_CRCAPP     = 5;
    // reset values
    localparam logic [7:0]  ERR_RST        = 8'h00;
    localparam logic [5:0]  CTRL_RST       = 6'h02;
    // timing counts in prescaled ticks; clock and tick periods in ns, prescaler in cycles, byte limit
    localparam logic [11:0] TTO_STD        = 12'd1000;
    localparam logic [11:0] TTO_QUAD       = 12'd4000;
    localparam int          TICK_NS        = 1000;
    localparam int          CLK_NS         = 10;
    localparam int          PRESC_CYC      = TICK_NS / CLK_NS;
    localparam int          FILT_US        = 7;
    localparam int          TV1_US         = 35;
    localparam int          SYM_MID_US     = 96;
    localparam int          SOF_MIN_US     = 163;
    localparam int          EOD_US         = 163;
    localparam int          EOF_US         = 239;
    localparam int          BRK_US         = 240;
    localparam logic [3:0]  MAX_BYTES      = 4'd12;
endpackage : vbe_pkg

//--- hw/vbe_error_flags.sv
module vbe_error_flags #(
    parameter int TIMEOUT_STD = 1000,
    parameter int TIMEOUT_QUAD = 4000
) (
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        bus_rx_pin,
    output logic             bus_tx_pin,
    input  wire logic        tx_abort_evt,
    output logic             tx_ready_flag
);
    typedef enum logic [3:0] {
        RX_IDLE = 4'b0001,
        RX_SOF  = 4'b0010,
        RX_DATA = 4'b0100,
        RX_HOLD = 4'b1000
    } vbe_rx_e;

    typedef struct packed {
        logic [1:0]  rx_sync;
        logic        rx_lvl;
        logic [7:0]  presc;
        logic [11:0] tto_cnt;
        logic [9:0]  lvl_us;
        logic [5:0]  ctrl;
        logic [7:0]  err;
        logic [7:0]  rx_byte_reg;
        logic        rx_full;
        logic [7:0]  rx_shift;
        logic [2:0]  bit_cnt;
        logic [3:0]  byte_cnt;
        logic [7:0]  crc;
        logic        eod_seen;
        vbe_rx_e     rx_st;
        logic        in_brk;
        logic [7:0]  tx_byte_reg;
        logic        tx_q;
        logic        tx_busy;
        logic [3:0]  tx_bits;
        logic        tx_ready;
        logic        bus_tx;
        logic [31:0] rdata;
        logic        rdy;
        logic        serr;
    } vbe_st_s;

    vbe_st_s st_ff;
    vbe_st_s nxt_st;

    function automatic logic [7:0] crc8(input logic [7:0] c, input logic b);
        logic fb;
        fb = c[7] ^ b;
        crc8 = {c[6:0], 1'b0} ^ (fb ? 8'h1D : 8'h00);
    endfunction : crc8

    localparam logic [11:0] TTO_N = 12'(TIMEOUT_STD);
    localparam logic [11:0] TTO_Q = 12'(TIMEOUT_QUAD);

    logic        tick;
    logic        en;
    logic        frz;
    logic        quiet;
    logic        sym_end;
    logic        ev_ibd;
    logic        ev_ifd;
    logic        ev_crc;
    logic        ev_brk;
    logic        ev_tto;
    logic        ev_rx_overrun_flag;
    logic        ev_tx_underflow_flag;
    logic        ev_eof;
    logic        rd_err;
    logic        acc;
    logic        done;
    logic        dbit;
    logic [7:0]  set_v;
    logic [7:0]  clr_v;
    logic [9:0]  len;

    always_comb begin
        nxt_st = st_ff;
        // taken on the first access edge, committed on the completion edge
        acc = psel && penable && !st_ff.rdy;
        done = psel && penable && st_ff.rdy;
        rd_err = done && !pwrite && paddr == vbe_pkg::ERR_ADDR;
        en = st_ff.ctrl[vbe_pkg::BIT_EN];
        frz = st_ff.ctrl[vbe_pkg::BIT_FRZ];
        nxt_st.rx_sync = {st_ff.rx_sync[0], bus_rx_pin};
        // one prescaled tick per microsecond
        // single tick
        tick = st_ff.presc == 8'(vbe_pkg::PRESC_CYC - 1);
        nxt_st.presc = tick ? 8'h00 : st_ff.presc + 8'h01;
        ev_ibd = 1'b0;
        ev_ifd = 1'b0;
        ev_crc = 1'b0;
        ev_brk = 1'b0;
        ev_tto = 1'b0;
        ev_rx_overrun_flag = 1'b0;
        ev_tx_underflow_flag = 1'b0;
        ev_eof = 1'b0;
        len = st_ff.lvl_us;
        dbit = st_ff.rx_lvl ^ (len > 10'(vbe_pkg::SYM_MID_US));
        quiet = st_ff.ctrl[vbe_pkg::BIT_SLEEP] && !st_ff.tx_busy;
        sym_end = tick && st_ff.rx_sync[1] != st_ff.rx_lvl;
        if (tick) begin
            nxt_st.rx_lvl = st_ff.rx_sync[1];
            nxt_st.lvl_us = sym_end ? 10'd1 : (&st_ff.lvl_us ? st_ff.lvl_us
                                               : st_ff.lvl_us + 10'd1);
        end
        if (tick && st_ff.rx_lvl && !st_ff.in_brk && st_ff.lvl_us ==
            10'(st_ff.ctrl[vbe_pkg::BIT_QUAD] ? vbe_pkg::BRK_US * 4 : vbe_pkg::BRK_US)) begin
            ev_brk = 1'b1;
        end
        if (tick && !st_ff.rx_lvl && st_ff.lvl_us == 10'(vbe_pkg::EOF_US)) begin
            ev_eof = 1'b1;
        end
        if (ev_brk) begin
            nxt_st.in_brk = 1'b1;
            nxt_st.rx_st = RX_HOLD;
        end
        if (ev_eof) begin
            nxt_st.in_brk = 1'b0;
            nxt_st.rx_st = RX_SOF;
            nxt_st.byte_cnt = 4'h0;
            nxt_st.eod_seen = 1'b0;
        end else if (tick && !st_ff.rx_lvl && st_ff.lvl_us == 10'(vbe_pkg::EOD_US)) begin
            unique case (st_ff.rx_st)
                RX_DATA: begin
                    if (st_ff.bit_cnt != 3'd0) begin
                        ev_ifd = 1'b1;
                    end else begin
                        ev_crc = st_ff.crc != 8'hC4;
                        nxt_st.crc = 8'hFF;
                        ev_ifd = st_ff.eod_seen;
                        nxt_st.eod_seen = 1'b1;
                    end
                end
                RX_IDLE, RX_SOF, RX_HOLD: begin
                end
            endcase
        end
        if (sym_end && st_ff.rx_st != RX_HOLD) begin
            if (len > 10'(vbe_pkg::FILT_US) && len < 10'(vbe_pkg::TV1_US)) begin
                ev_ibd = 1'b1;
            end else if (st_ff.rx_lvl && len >= 10'(vbe_pkg::SOF_MIN_US)) begin
                ev_ifd = st_ff.rx_st == RX_DATA;
                nxt_st.rx_st = RX_DATA;
                nxt_st.crc = 8'hFF;
                nxt_st.bit_cnt = 3'd0;
            end else if (st_ff.rx_lvl && st_ff.rx_st == RX_SOF) begin
                ev_ifd = 1'b1;
            end else if (st_ff.rx_st == RX_DATA) begin
                nxt_st.rx_shift = {st_ff.rx_shift[6:0], dbit};
                nxt_st.crc = crc8(st_ff.crc, dbit);
                nxt_st.bit_cnt = st_ff.bit_cnt + 3'd1;
                if (!st_ff.ctrl[vbe_pkg::BIT_NFL] && st_ff.byte_cnt == vbe_pkg::MAX_BYTES) begin
                    ev_ifd = 1'b1;
                end
                if (st_ff.bit_cnt == 3'd7) begin
                    nxt_st.byte_cnt = st_ff.byte_cnt + 4'h1;
                    if (!st_ff.ctrl[vbe_pkg::BIT_SLEEP]) begin
                        ev_rx_overrun_flag = st_ff.rx_full;
                        nxt_st.rx_byte_reg = {st_ff.rx_shift[6:0], dbit};
                        nxt_st.rx_full = 1'b1;
                    end
                end
            end
        end
        if (quiet) begin
            ev_ibd = 1'b0;
            ev_ifd = 1'b0;
            ev_crc = 1'b0;
        end
        if (ev_ibd || ev_ifd || ev_crc) begin
            nxt_st.rx_st = RX_HOLD;
            nxt_st.tx_q = 1'b0;
        end
        if (ev_brk) begin
            nxt_st.tx_q = 1'b0;
            nxt_st.tx_busy = 1'b0;
        end
        // transmit byte engine, one bit per tick
        if (tick && st_ff.tx_busy) begin
            nxt_st.tx_bits = st_ff.tx_bits - 4'h1;
            if (st_ff.tx_bits == 4'h1) begin
                if (st_ff.tx_q) begin
                    nxt_st.tx_q = 1'b0;
                    nxt_st.tx_bits = 4'd8;
                    nxt_st.tx_ready = 1'b1;
                end else if (!st_ff.ctrl[vbe_pkg::BIT_CRCAPP]) begin
                    ev_tx_underflow_flag = 1'b1;
                    nxt_st.tx_byte_reg = ~st_ff.crc;
                    nxt_st.tx_bits = 4'd8;
                    nxt_st.ctrl[vbe_pkg::BIT_CRCAPP] = 1'b1;
                end else begin
                    nxt_st.tx_busy = 1'b0;
                end
            end
        end
        nxt_st.bus_tx = st_ff.tx_busy && !st_ff.err[vbe_pkg::BIT_TTO] && en;
        if (tick) begin
            nxt_st.tto_cnt = st_ff.bus_tx ? st_ff.tto_cnt + 12'h001 : 12'h000;
        end
        if (tick && st_ff.bus_tx && st_ff.tto_cnt ==
            (st_ff.ctrl[vbe_pkg::BIT_QUAD] ? TTO_Q : TTO_N) - 12'h001) begin
            ev_tto = 1'b1;
        end
        if (ev_tto || st_ff.err[vbe_pkg::BIT_TTO]) begin
            nxt_st.bus_tx = 1'b0;
            nxt_st.tx_busy = 1'b0;
            nxt_st.tx_q = 1'b0;
        end
        // apb slave, one wait state; effects land on the completion edge
        nxt_st.rdy = acc;
        nxt_st.serr = 1'b0;
        nxt_st.rdata = 32'h0000_0000;
        if (acc) begin
            unique case (paddr)
                vbe_pkg::CTRL_ADDR: begin
                    nxt_st.rdata = {26'h0, st_ff.ctrl};
                end
                vbe_pkg::RXD_ADDR: begin
                    nxt_st.rdata = {23'h0, st_ff.rx_full, st_ff.rx_byte_reg};
                end
                vbe_pkg::TXD_ADDR: begin
                    nxt_st.rdata = {23'h0, st_ff.tx_ready, st_ff.tx_byte_reg};
                end
                vbe_pkg::ERR_ADDR: begin
                    nxt_st.rdata = {24'h0, st_ff.err};
                end
                default: begin
                    nxt_st.serr = 1'b1;
                end
            endcase
        end
        if (done) begin
            unique case (paddr)
                vbe_pkg::CTRL_ADDR: begin
                    if (pwrite) begin
                        nxt_st.ctrl = pwdata[5:0];
                    end
                end
                vbe_pkg::RXD_ADDR: begin
                    if (!pwrite) begin
                        nxt_st.rx_full = 1'b0;
                    end
                end
                vbe_pkg::TXD_ADDR: begin
                    if (pwrite && !tx_abort_evt) begin
                        nxt_st.tx_byte_reg = pwdata[7:0];
                        nxt_st.ctrl[vbe_pkg::BIT_CRCAPP] = pwdata[8];
                        nxt_st.tx_ready = 1'b0;
                        if (st_ff.tx_busy) begin
                            nxt_st.tx_q = 1'b1;
                        end else begin
                            nxt_st.tx_busy = 1'b1;
                            nxt_st.tx_bits = 4'd8;
                        end
                    end
                end
                vbe_pkg::ERR_ADDR: begin
                end
                default: begin
                end
            endcase
        end
        set_v = 8'h00;
        set_v[vbe_pkg::BIT_TTO] = ev_tto;
        set_v[vbe_pkg::BIT_TX_UNDERFLOW_FLAG] = ev_tx_underflow_flag;
        set_v[vbe_pkg::BIT_RX_OVERRUN_FLAG] = ev_rx_overrun_flag;
        set_v[vbe_pkg::BIT_TRA] = tx_abort_evt;
        set_v[vbe_pkg::BIT_RX_BREAK_FLAG] = ev_brk;
        set_v[vbe_pkg::BIT_RX_CHECKSUM_ERROR_FLAG] = ev_crc && st_ff.rx_st != RX_HOLD;
        set_v[vbe_pkg::BIT_IFD] = ev_ifd && st_ff.rx_st != RX_HOLD;
        set_v[vbe_pkg::BIT_IBD] = ev_ibd;
        clr_v = rd_err ? st_ff.rdata[7:0] : 8'h00;
        clr_v[vbe_pkg::BIT_TTO] = 1'b0;
        if (st_ff.in_brk) begin
            clr_v[vbe_pkg::BIT_RX_BREAK_FLAG] = 1'b0;
        end
        nxt_st.err = (st_ff.err & ~clr_v) | set_v;
        if (!en || frz) begin
            nxt_st.err = vbe_pkg::ERR_RST;
            nxt_st.rx_st = RX_IDLE;
            nxt_st.tx_busy = 1'b0;
            nxt_st.tx_q = 1'b0;
            nxt_st.bus_tx = 1'b0;
            nxt_st.tto_cnt = 12'h000;
            nxt_st.in_brk = 1'b0;
            nxt_st.tx_ready = 1'b1;
            nxt_st.lvl_us = 10'd0;
            nxt_st.byte_cnt = 4'h0;
            nxt_st.eod_seen = 1'b0;
        end else if (st_ff.rx_st == RX_IDLE) begin
            nxt_st.rx_st = RX_HOLD;
        end
        // sleep after timeout
        if (ev_tto) begin
            nxt_st.ctrl[vbe_pkg::BIT_SLEEP] = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= '{rx_st: RX_IDLE, ctrl: vbe_pkg::CTRL_RST, err: vbe_pkg::ERR_RST,
                       tx_ready: 1'b1, crc: 8'hFF, default: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata = st_ff.rdata;
    assign pready = st_ff.rdy;
    assign pslverr = st_ff.serr;
    assign bus_tx_pin = st_ff.bus_tx;
    assign tx_ready_flag = st_ff.tx_ready;
endmodule : vbe_error_flags

//--- test/vbe_error_flags_assertions.sv
module vbe_error_flags_checker #(
    parameter int TIMEOUT_STD  = 1000,
    parameter int TIMEOUT_QUAD = 4000
) (
    input wire logic        core_clk,
    input wire logic        reset_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        bus_rx_pin,
    input wire logic        bus_tx_pin,
    input wire logic        tx_abort_evt,
    input wire logic        tx_ready_flag
);
    localparam int TX_LIM = (TIMEOUT_QUAD + 1) * vbe_pkg::PRESC_CYC;
    int   tx_cnt_ff;
    logic mapped;
    logic taken;

    assign mapped = paddr inside {vbe_pkg::CTRL_ADDR, vbe_pkg::RXD_ADDR,
                                  vbe_pkg::TXD_ADDR, vbe_pkg::ERR_ADDR};
    assign taken = psel && penable && !pready;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_cnt_ff <= 0;
        end else begin
            tx_cnt_ff <= bus_tx_pin ? tx_cnt_ff + 1 : 0;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    a_ready_wait: assert property (taken |=> pready)
        else $error("access not answered after one wait state");
    a_ready_idle: assert property (!(psel && penable) |=> !pready)
        else $error("pready without an access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_slverr_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_slverr_unmapped: assert property (taken && !mapped |=> pslverr)
        else $error("unmapped access not refused");
    a_slverr_mapped: assert property (taken && mapped |=> !pslverr)
        else $error("mapped access refused");
    a_read_upper: assert property (pready && !pwrite && $past(paddr) == vbe_pkg::ERR_ADDR
                                   |-> prdata[31:8] == 24'h000000)
        else $error("error read upper bits not zero");
    a_abort_ready: assert property (tx_abort_evt && tx_ready_flag |=> tx_ready_flag)
        else $error("abort cleared transmit ready");
    a_tx_bounded: assert property (bus_tx_pin |-> tx_cnt_ff <= TX_LIM)
        else $error("transmit pin active past the timeout");

    c_refused: cover property (pready && pslverr);
    c_abort: cover property (tx_abort_evt);
    c_tx_drop: cover property (bus_tx_pin ##1 !bus_tx_pin);
endmodule : vbe_error_flags_checker

bind vbe_error_flags vbe_error_flags_checker #(
    .TIMEOUT_STD (TIMEOUT_STD),
    .TIMEOUT_QUAD(TIMEOUT_QUAD)
) vbe_error_flags_checker_i (.*);

//--- test/vbe_bus_node.sv
module vbe_bus_node (
    input  wire logic core_clk,
    input  wire logic bus_tx_pin,
    output logic      bus_rx_pin
);
    timeunit 1ns;
    timeprecision 1ns;

    // bus shorted passive: transmit never echoed, so the timeout can trip
    initial bus_rx_pin = 1'b0;

    task automatic hold(input logic lvl, input int us);
        bus_rx_pin <= lvl;
        repeat (us * vbe_pkg::PRESC_CYC) @(posedge core_clk);
    endtask : hold
endmodule : vbe_bus_node

//--- test/vbe_error_flags_tb_top.sv
module vbe_error_flags_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TO = 10;
    logic        core_clk     = 1'b0;
    logic        reset_n      = 1'b0;
    logic        psel         = 1'b0;
    logic        penable      = 1'b0;
    logic        pwrite       = 1'b0;
    logic        tx_abort_evt = 1'b0;
    logic [11:0] paddr        = 12'h000;
    logic [31:0] pwdata       = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, er, bus_rx_pin, bus_tx_pin, tx_ready_flag;
    int          miscompares  = 0;
    int          checked      = 0;

    always #5 core_clk = ~core_clk;

    vbe_error_flags #(.TIMEOUT_STD(TO), .TIMEOUT_QUAD(4 * TO)) vbe_error_flags_i (
        .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .bus_rx_pin(bus_rx_pin),
        .bus_tx_pin(bus_tx_pin), .tx_abort_evt(tx_abort_evt),
        .tx_ready_flag(tx_ready_flag));
    vbe_bus_node vbe_bus_node_i (
        .core_clk(core_clk), .bus_tx_pin(bus_tx_pin), .bus_rx_pin(bus_rx_pin));

    task automatic results();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            miscompares++;
            results();
        end
    endtask : apb

    task automatic err_is(input logic [7:0] mask, input logic [7:0] exp);
        apb(1'b0, vbe_pkg::ERR_ADDR, 32'h0);
        chk("bus_error_flags", rd & {24'h0, mask}, {24'h0, exp});
    endtask : err_is

    task automatic abort_pulse();
        @(posedge core_clk);
        tx_abort_evt <= 1'b1;
        @(posedge core_clk);
        tx_abort_evt <= 1'b0;
        @(posedge core_clk);
    endtask : abort_pulse

    task automatic t_reset();
        err_is(8'hFF, vbe_pkg::ERR_RST);
        chk("tx_ready_flag", 32'(tx_ready_flag), 32'h1);
        chk("bus_tx_pin", 32'(bus_tx_pin), 32'h0);
        apb(1'b0, vbe_pkg::CTRL_ADDR, 32'h0);
        chk("ctrl", rd, {26'h0, vbe_pkg::CTRL_RST});
        apb(1'b0, 12'h100, 32'h0);
        chk("pslverr", 32'(er), 32'h1);
        apb(1'b1, vbe_pkg::CTRL_ADDR, 32'h0);
        apb(1'b1, vbe_pkg::CTRL_ADDR, 32'h1);
        $display("t_reset done");
    endtask : t_reset

    task automatic t_bad_bit();
        vbe_bus_node_i.hold(1'b0, 245);
        vbe_bus_node_i.hold(1'b1, 20);
        vbe_bus_node_i.hold(1'b0, 245);
        err_is(8'h01, 8'h01);
        $display("t_bad_bit done");
    endtask : t_bad_bit

    task automatic t_break();
        vbe_bus_node_i.hold(1'b1, 245);
        err_is(8'h08, 8'h08);
        err_is(8'h08, 8'h08);
        vbe_bus_node_i.hold(1'b0, 245);
        err_is(8'h08, 8'h08);
        err_is(8'h08, 8'h00);
        $display("t_break done");
    endtask : t_break

    task automatic t_abort();
        abort_pulse();
        chk("tx_ready_flag", 32'(tx_ready_flag), 32'h1);
        err_is(8'hFF, 8'h10);
        err_is(8'hFF, 8'h00);
        abort_pulse();
        apb(1'b1, vbe_pkg::CTRL_ADDR, 32'h2);
        err_is(8'hFF, 8'h00);
        apb(1'b1, vbe_pkg::CTRL_ADDR, 32'h0);
        apb(1'b1, vbe_pkg::CTRL_ADDR, 32'h1);
        $display("t_abort done");
    endtask : t_abort

    task automatic t_timeout();
        int n;
        n = 0;
        apb(1'b1, vbe_pkg::TXD_ADDR, 32'h0000_0055);
        while (bus_tx_pin !== 1'b1 && n < 1000) begin
            @(posedge core_clk);
            n++;
        end
        n = 0;
        while (bus_tx_pin === 1'b1 && n < 2 * TO * 100) begin
            @(posedge core_clk);
            n++;
        end
        chk("tx_high", 32'(n >= (TO - 1) * 100 && n <= (TO + 1) * 100), 32'h1);
        chk("bus_tx_pin", 32'(bus_tx_pin), 32'h0);
        err_is(8'hFF, 8'hC0);
        err_is(8'hFF, 8'h80);
        apb(1'b1, vbe_pkg::CTRL_ADDR, 32'h0);
        err_is(8'hFF, 8'h00);
        apb(1'b1, vbe_pkg::CTRL_ADDR, 32'h1);
        $display("t_timeout done");
    endtask : t_timeout

    initial begin
        repeat (6) @(posedge core_clk);
        reset_n <= 1'b1;
        t_reset();
        t_bad_bit();
        t_break();
        t_abort();
        t_timeout();
        results();
    end
endmodule : vbe_error_flags_tb_top
